/* sbs_sram.sv */
// Synchronous burst SRAM core: input registers, burst counter, array and
// a two-entry read buffer feeding the three-state data lines.
// Assumes pins are synchronous to clock (setup/hold met, as for a real part);
// data_lines are split into in/out/enable, the board resolves the wire.
`timescale 1ns/1ps
module sbs_sram
  import sbs_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr_inputs,
  input  wire logic [DATA_W-1:0] data_lines_in,
  output logic      [DATA_W-1:0] data_lines_out,
  output logic                   data_lines_oe,
  input  wire logic              write_en_n,
  input  wire logic              out_en_n,
  input  wire logic              proc_addr_strobe_n,
  input  wire logic              ctrl_addr_strobe_n,
  input  wire logic              burst_step_n,
  input  wire logic              chip_sel_high,
  input  wire logic              chip_sel_low_n,
  input  wire logic              rd_ready,
  output logic                   rd_valid,
  output logic                   req_ready
);

  // ------------------------------------------------------------
  // Input registers
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] in_addr;
  logic [DATA_W-1:0] in_data;
  logic              in_we_n;
  logic              in_padsn;
  logic              in_cadsn;
  logic              in_advn;
  logic              in_cs_h;
  logic              in_cs_ln;

  // Rising-edge capture of every input except output enable and rd_ready
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_addr  <= '0;
      in_data  <= '0;
      in_we_n  <= 1'b1;
      in_padsn <= 1'b1;
      in_cadsn <= 1'b1;
      in_advn  <= 1'b1;
      in_cs_h  <= 1'b0;
      in_cs_ln <= 1'b1;
    end else begin
      in_addr  <= addr_inputs;
      in_data  <= data_lines_in;
      in_we_n  <= write_en_n;
      in_padsn <= proc_addr_strobe_n;
      in_cadsn <= ctrl_addr_strobe_n;
      in_advn  <= burst_step_n;
      in_cs_h  <= chip_sel_high;
      in_cs_ln <= chip_sel_low_n;
    end
  end

  // ------------------------------------------------------------
  // Burst control
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SBS_IDLE, SBS_BURST} sbs_state_t;

  sbs_state_t        state;
  sbs_state_t        next_state;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [BURST_W-1:0] count;
  logic [BURST_W-1:0] next_count;
  logic              sel;
  logic              next_sel;
  logic              burst_wr;
  logic              next_burst_wr;

  logic              load;
  logic              cur_wr;
  logic              access;
  logic [ADDR_W-1:0] cur_addr;
  logic              acc_wr;

  // Either strobe loads a base; processor strobe forces a read
  assign load   = !in_padsn || !in_cadsn;
  assign cur_wr = in_padsn ? !in_we_n : 1'b0;

  always_comb begin
    next_state    = state;
    next_base     = base;
    next_count    = count;
    next_sel      = sel;
    next_burst_wr = burst_wr;
    if (load) begin
      next_state    = SBS_BURST;
      next_base     = in_addr;
      next_count    = '0;
      next_sel      = !in_cs_ln && in_cs_h;
      next_burst_wr = cur_wr;
    end else if (state == SBS_BURST) begin
      // Wraps through 3 back to 0, i.e. to the base address
      if (!in_advn) begin
        next_count = count + 2'd1;
      end
      next_burst_wr = !in_we_n;
    end
  end

  // Continuation cycles are qualified by the select latched at load
  always_comb begin
    access   = 1'b0;
    acc_wr   = 1'b0;
    cur_addr = base;
    if (load) begin
      access   = !in_cs_ln && in_cs_h;
      acc_wr   = cur_wr;
      cur_addr = in_addr;
    end else if (state == SBS_BURST) begin
      access   = sel;
      acc_wr   = !in_we_n;
      // Advance low steps before this access, high repeats it
      cur_addr = {base[ADDR_W-1:BURST_W],
                  sbs_burst_lsb(base[BURST_W-1:0],
                                in_advn ? count : BURST_W'(count + 2'd1))};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state    <= SBS_IDLE;
      base     <= '0;
      count    <= '0;
      sel      <= 1'b0;
      burst_wr <= 1'b0;
    end else begin
      state    <= next_state;
      base     <= next_base;
      count    <= next_count;
      sel      <= next_sel;
      burst_wr <= next_burst_wr;
    end
  end

  // ------------------------------------------------------------
  // Array
  // ------------------------------------------------------------
  logic [DATA_W-1:0] mem_rdata;
  logic              mem_en;
  logic              rd_pend;
  logic              next_rd_pend;
  logic [1:0]        buf_cnt;
  logic [2:0]        occ;

  // Occupancy counts the word still in flight from the array, otherwise a
  // read accepted behind a pending one would overrun the two entries
  assign occ       = {1'b0, buf_cnt} + {2'b00, rd_pend};
  assign req_ready = (occ < 3'(BUF_DEPTH)) || ((occ == 3'(BUF_DEPTH)) && rd_ready);
  assign mem_en    = access && (acc_wr || req_ready);

  sbs_mem #(
    .AW (ADDR_W),
    .DW (DATA_W)
  ) u_mem (
    .clock (clock),
    .en    (mem_en),
    .wr    (acc_wr),
    .addr  (cur_addr),
    .wdata (in_data),
    .rdata (mem_rdata)
  );

  assign next_rd_pend = mem_en && !acc_wr;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= next_rd_pend;
    end
  end

  // ------------------------------------------------------------
  // Two-entry read buffer
  // ------------------------------------------------------------
  sbs_rd_t           buf_mem [0:BUF_DEPTH-1];
  sbs_rd_t           next_buf_mem [0:BUF_DEPTH-1];
  logic [1:0]        next_buf_cnt;
  logic              pop;

  assign rd_valid = (buf_cnt != 2'd0);
  assign pop      = rd_valid && rd_ready;

  always_comb begin
    next_buf_mem[0] = buf_mem[0];
    next_buf_mem[1] = buf_mem[1];
    next_buf_cnt    = buf_cnt;
    if (pop) begin
      next_buf_mem[0] = buf_mem[1];
      next_buf_cnt    = buf_cnt - 2'd1;
    end
    if (rd_pend) begin
      next_buf_mem[next_buf_cnt[0]] = '{data: mem_rdata};
      next_buf_cnt                  = next_buf_cnt + 2'd1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      buf_cnt    <= '0;
    end else begin
      buf_mem[0] <= next_buf_mem[0];
      buf_mem[1] <= next_buf_mem[1];
      buf_cnt    <= next_buf_cnt;
    end
  end

  // ------------------------------------------------------------
  // Data line drivers
  // ------------------------------------------------------------
  logic drive_ok;
  logic next_drive_ok;

  // Drive window follows the last access; write cycles keep lines as inputs
  assign next_drive_ok = rd_pend || (rd_valid && !(access && acc_wr));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drive_ok <= 1'b0;
    end else begin
      drive_ok <= next_drive_ok;
    end
  end

  assign data_lines_out = buf_mem[0].data;
  // Output enable acts combinationally, bypassing the input registers
  assign data_lines_oe  = rd_valid && drive_ok && !out_en_n && in_we_n;

endmodule // sbs_sram

/* sbs_pkg.sv */
// Package for the synchronous burst SRAM: sizes, burst order, carrier structs.
// Assumes a single 250 MHz clock domain; no software-visible registers.
package sbs_pkg;

  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 9;
  localparam int DEPTH      = 32768;
  localparam int BURST_W    = 2;
  localparam int BUF_DEPTH  = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              wr;
  } sbs_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
  } sbs_rd_t;

  // Burst sequence: the two low bits are xor'ed with the count
  function automatic logic [BURST_W-1:0] sbs_burst_lsb(
    input logic [BURST_W-1:0] base,
    input logic [BURST_W-1:0] count
  );
    return base ^ count;
  endfunction

endpackage

/* sbs_mem.sv */
// Nine-bit wide single-port array with registered read data.
// Assumes one clock; the write is taken on the same edge as the request.
`timescale 1ns/1ps
module sbs_mem
  import sbs_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input  wire logic          clock,
  input  wire logic          en,
  input  wire logic          wr,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array; the read register is what the port sees
  always_ff @(posedge clock) begin
    if (en && wr) begin
      mem[addr] <= wdata;
    end
    if (en && !wr) begin
      rdata <= mem[addr];
    end
  end

endmodule // sbs_mem

/* sbs_reader.sv */
// Read-side consumer model for the burst SRAM core.
// Assumes it shares the core clock and reset.
`timescale 1ns/1ps
module sbs_reader (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic slow,
  output logic      rd_ready
);
  logic [2:0] cnt;
  // Slow mode takes one word in eight cycles so the buffer fills up
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cnt <= 3'h0;
    else cnt <= cnt + 3'h1;
  end
  assign rd_ready = !slow || (cnt == 3'h7);
endmodule // sbs_reader

/* sbs_sram_chk.sv */
// Port checker for the burst SRAM core.
// Assumes one clock and the async active-low reset.
`timescale 1ns/1ps
module sbs_sram_chk
  import sbs_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic              data_lines_oe,
  input wire logic              write_en_n,
  input wire logic              out_en_n,
  input wire logic              proc_addr_strobe_n,
  input wire logic              ctrl_addr_strobe_n,
  input wire logic              chip_sel_high,
  input wire logic              chip_sel_low_n,
  input wire logic              rd_ready,
  input wire logic              rd_valid,
  input wire logic              req_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic sel, wr_ld, wr_go;
  assign sel   = chip_sel_high && !chip_sel_low_n;
  assign wr_ld = proc_addr_strobe_n && !ctrl_addr_strobe_n && !write_en_n && sel;
  assign wr_go = proc_addr_strobe_n && ctrl_addr_strobe_n && !write_en_n;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_oe_off; out_en_n |-> !data_lines_oe; endproperty
  property p_wr_hiz; (!$past(write_en_n) && $past(proc_addr_strobe_n)) |-> !data_lines_oe;
  endproperty
  property p_rd_lat; (!proc_addr_strobe_n && sel && req_ready) |-> ##[1:3] rd_valid; endproperty
  property p_ctrl_rd;
    (proc_addr_strobe_n && !ctrl_addr_strobe_n && write_en_n && sel && req_ready)
      |-> ##[1:3] rd_valid;
  endproperty
  property p_desel; (!proc_addr_strobe_n && !sel && rd_ready)[*6] |-> !rd_valid; endproperty
  property p_wr_none;
    (wr_ld && !rd_valid) ##1 (wr_go && !rd_valid)[*2] ##1 wr_go |-> !rd_valid;
  endproperty
  property p_hold; rd_valid && !rd_ready |=> rd_valid && $stable(data_lines_out); endproperty
  property p_full; !req_ready |-> rd_valid; endproperty
  a_oe_off:  assert property (p_oe_off) else $error("oe high while disabled");
  a_wr_hiz:  assert property (p_wr_hiz) else $error("oe high on write");
  a_rd_lat:  assert property (p_rd_lat) else $error("no read data");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("no ctrl read data");
  a_desel:   assert property (p_desel) else $error("data while deselected");
  a_wr_none: assert property (p_wr_none) else $error("write produced data");
  a_hold:    assert property (p_hold) else $error("read word lost in stall");
  a_full:    assert property (p_full) else $error("full with no data");
  c_stall: cover property (rd_valid && !rd_ready);
  c_full:  cover property (!req_ready);
  c_wr:    cover property (wr_ld);
endmodule // sbs_sram_chk

bind sbs_sram sbs_sram_chk u_sbs_sram_chk (.clock(clock), .rst_n(rst_n),
  .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .write_en_n(write_en_n),
  .out_en_n(out_en_n), .proc_addr_strobe_n(proc_addr_strobe_n),
  .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .chip_sel_high(chip_sel_high),
  .chip_sel_low_n(chip_sel_low_n), .rd_ready(rd_ready), .rd_valid(rd_valid),
  .req_ready(req_ready));

/* sbs_sram_tb.sv */
// Self-checking bench for the burst SRAM core with a read consumer model.
// Assumes the core answers reads in order through its two-entry buffer.
`timescale 1ns/1ps
module sbs_sram_tb
  import sbs_pkg::*;
;
  logic              clock, rst_n, we_n, oe_n, ps_n, ca_n, step_n, cs_hi, cs_lo_n, slow;
  logic              dq_oe, rd_ready, rd_valid, req_ready, act, ld_wr;
  logic [ADDR_W-1:0] addr, base, a;
  logic [DATA_W-1:0] drv, dq_out, dq_in;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] expq [$];
  logic [1:0]        cnt;
  int                bad_count, compares, seed;
  assign dq_in = dq_oe ? dq_out : drv;
  sbs_sram u_sbs_sram (.clock(clock), .rst_n(rst_n), .addr_inputs(addr), .data_lines_in(dq_in),
    .data_lines_out(dq_out), .data_lines_oe(dq_oe), .write_en_n(we_n), .out_en_n(oe_n),
    .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(ca_n), .burst_step_n(step_n),
    .chip_sel_high(cs_hi), .chip_sel_low_n(cs_lo_n), .rd_ready(rd_ready),
    .rd_valid(rd_valid), .req_ready(req_ready));
  sbs_reader u_sbs_reader (.clock(clock), .rst_n(rst_n), .slow(slow), .rd_ready(rd_ready));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // One bus cycle plus the reference model of the array
  // ---------------------------------------------------------------
  task automatic cyc(input logic p, c, w, s, sh, sl, input logic [ADDR_W-1:0] ad,
                     input logic [DATA_W-1:0] d);
    logic [ADDR_W-1:0] ea;
    @(posedge clock);
    ps_n <= p; ca_n <= c; we_n <= w; step_n <= s; cs_hi <= sh; cs_lo_n <= sl;
    addr <= ad; drv <= d; oe_n <= 1'($random(seed));
    if (!p || !c) begin
      act = sh && !sl; base = ad; cnt = 2'h0; ld_wr = p && !w;
    end else begin
      if (!s) cnt++;
      ld_wr = !w;
    end
    ea = {base[ADDR_W-1:2], base[1:0] ^ cnt};
    if (act && ld_wr) mem[ea] = d;
    else if (act) expq.push_back(mem[ea]);
  endtask
  task automatic idle(input int n);
    logic r;
    repeat (n) begin
      r = 1'($random(seed));
      cyc(1'b0, 1'b1, 1'b1, 1'b1, r, r, ADDR_W'($random(seed)), DATA_W'($random(seed)));
    end
  endtask
  task automatic burst(input logic wr, ctrl, rs, input int n, input logic [ADDR_W-1:0] ad);
    cyc(ctrl, !ctrl, !wr, 1'b1, 1'b1, 1'b0, ad, DATA_W'($random(seed)));
    repeat (n) cyc(1'b1, 1'b1, ctrl ? !wr : 1'b1, rs && ($random(seed) % 4 == 0), 1'b1,
                   1'b0, ADDR_W'($random(seed)), DATA_W'($random(seed)));
  endtask
  always @(posedge clock) begin
    if (rst_n && rd_valid === 1'b1 && rd_ready === 1'b1) begin
      if (expq.size() == 0) begin
        bad_count++;
        $display("MISMATCH read_count exp 0 got 1");
      end else chk("read_word", expq.pop_front(), dq_out);
    end
  end
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    $display("MISMATCH watchdog exp done got hang");
    conclude();
  end
  initial begin
    seed = 32'h831d3261; bad_count = 0; compares = 0; rst_n = 1'b0; slow = 1'b0;
    we_n = 1'b1; oe_n = 1'b1; ps_n = 1'b1; ca_n = 1'b1; step_n = 1'b1; cs_hi = 1'b0;
    cs_lo_n = 1'b1; addr = '0; drv = '0; act = 1'b0; cnt = 2'h0; base = '0; ld_wr = 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? '1 : ADDR_W'($random(seed));
      burst(1'b1, 1'b1, 1'b0, 3, a);
      cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, a, 9'h1FF);
      repeat (3) cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, a, 9'h155);
      idle(2);
      burst(1'b1, 1'b0, 1'b1, 8, a);
      idle(6);
      burst(1'b0, 1'b1, 1'b1, 8, a);
      idle(6);
    end
    @(posedge clock);
    slow <= 1'b1;
    repeat (4) begin
      cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, a, 9'h000);
      cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, a ^ ADDR_W'(1), 9'h000);
      idle(24);
    end
    @(posedge clock);
    slow <= 1'b0;
    idle(6);
    chk("pending_reads", '0, DATA_W'(expq.size()));
    conclude();
  end
endmodule // sbs_sram_tb
